// [logic/asfr_regs.vh]
// Offsets, field positions and reset values of the ALU condition flag register
`ifndef ASFR_REGS_VH
`define ASFR_REGS_VH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ASFR_FLAGS_OFS 8'h00
`define ASFR_OPCTL_OFS 8'h04
`define ASFR_OPERAND_OFS 8'h08
`define ASFR_RESULT_OFS 8'h0c
// ****************************************
// Flag field positions
// ****************************************
`define ASFR_BIT_C 0
`define ASFR_BIT_NIB 1
`define ASFR_BIT_Z 2
`define ASFR_BIT_SOV 3
`define ASFR_BIT_N 4
`define ASFR_FLAG_MASK 8'h1f
// ****************************************
// Operation codes
// ****************************************
`define ASFR_OP_ADD 4'h0
`define ASFR_OP_SUB 4'h1
`define ASFR_OP_AND 4'h2
`define ASFR_OP_IOR 4'h3
`define ASFR_OP_XOR 4'h4
`define ASFR_OP_CLR 4'h5
`define ASFR_OP_BSET 4'h6
`define ASFR_OP_BCLR 4'h7
`define ASFR_OP_SWAP 4'h8
`define ASFR_OP_FMOV 4'h9
`define ASFR_OP_AMOV 4'ha
`define ASFR_OP_MOVF 4'hb
// ****************************************
// Reset values and bus response codes
// ****************************************
`define ASFR_FLAGS_RST 8'h00
`define ASFR_OPCTL_RST 32'h0000_0000
`define ASFR_RESP_OKAY 2'b00
`define ASFR_RESP_SLVERR 2'b10
`endif

// [logic/asfr_core.v]
// ALU condition flag register with an AXI4-Lite register port
//
// What this block does
// - The flag register is read and written like the operand register, but its bits 7 to 5 always stay zero.
// - A flag-changing op aimed at the flags drops its computed result.
// - Clearing the flags sets zero, keeps the rest, zeroes bits 7 to 5.
// - Bit set, bit clear, swap and both moves leave the five flags alone unless aimed at them.
// - Subtraction uses carry and nibble carry as not-borrow flags.
// - The negative flag in bit 4 copies the result's top bit.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "asfr_regs.vh"
module asfr_core (
	input wire clk_sys,
	input wire rst_n,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [7:0] alu_condition_flags_ff
);
// ****************************************
// Register state
// ****************************************
reg [7:0] operand_ff;
reg [7:0] result_ff;
reg [31:0] opctl_ff;
reg [7:0] nxt_flags;
reg [7:0] nxt_result;
reg aw_held_ff;
reg w_held_ff;
reg [7:0] awaddr_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
wire [3:0] op_code = opctl_ff[3:0];
wire to_flags = opctl_ff[4];
wire [2:0] bit_sel = opctl_ff[10:8];
wire [7:0] literal = opctl_ff[23:16];
wire do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
wire op_go = do_write && awaddr_ff == `ASFR_OPCTL_OFS && wstrb_ff[0];
// Source read of the file side: flags register or operand register
wire [7:0] file_src = to_flags ? alu_condition_flags_ff : operand_ff;
// ****************************************
// Byte lane merge
// ****************************************
function [31:0] merge;
	input [31:0] old_v;
	input [31:0] new_v;
	input [3:0] strb;
	integer i;
	begin
		merge = old_v;
		for (i = 0; i < 4; i = i + 1) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
	end
endfunction
// ****************************************
// ALU and flag update
// ****************************************
reg [8:0] sum;
reg [4:0] nib;
reg [7:0] res;
reg arith;
reg logic_op;
reg keep;
always @* begin
	sum = 9'h000;
	nib = 5'h00;
	res = 8'h00;
	arith = 1'b0;
	logic_op = 1'b0;
	keep = 1'b1;
	nxt_flags = alu_condition_flags_ff;
	nxt_result = result_ff;
	case (op_code)
		`ASFR_OP_ADD: begin
			sum = {1'b0, file_src} + {1'b0, literal};
			nib = {1'b0, file_src[3:0]} + {1'b0, literal[3:0]};
			res = sum[7:0];
			arith = 1'b1;
		end
		`ASFR_OP_SUB: begin
			// Two's complement add; carries act as not-borrow
			sum = {1'b0, file_src} + {1'b0, ~literal} + 9'h001;
			nib = {1'b0, file_src[3:0]} + {1'b0, ~literal[3:0]} + 5'h01;
			res = sum[7:0];
			arith = 1'b1;
		end
		`ASFR_OP_AND: begin
			res = file_src & literal;
			logic_op = 1'b1;
		end
		`ASFR_OP_IOR: begin
			res = file_src | literal;
			logic_op = 1'b1;
		end
		`ASFR_OP_XOR: begin
			res = file_src ^ literal;
			logic_op = 1'b1;
		end
		`ASFR_OP_MOVF: begin
			res = file_src;
			logic_op = 1'b1;
		end
		`ASFR_OP_CLR: begin
			res = 8'h00;
			// Only zero changes; top bits are unimplemented
			nxt_flags = (alu_condition_flags_ff & `ASFR_FLAG_MASK)
				| (8'h01 << `ASFR_BIT_Z);
			keep = 1'b0;
		end
		`ASFR_OP_BSET: res = file_src | (8'h01 << bit_sel);
		`ASFR_OP_BCLR: res = file_src & ~(8'h01 << bit_sel);
		`ASFR_OP_SWAP: res = {file_src[3:0], file_src[7:4]};
		`ASFR_OP_FMOV: res = operand_ff;
		`ASFR_OP_AMOV: res = literal;
		default: res = file_src;
	endcase
	if (arith) begin
		nxt_flags[`ASFR_BIT_C] = sum[8];
		nxt_flags[`ASFR_BIT_NIB] = nib[4];
		nxt_flags[`ASFR_BIT_SOV] = (file_src[7] ==
			(op_code == `ASFR_OP_SUB ? ~literal[7] : literal[7]))
			&& (res[7] != file_src[7]);
	end
	if (arith || logic_op) begin
		nxt_flags[`ASFR_BIT_Z] = (res == 8'h00);
		nxt_flags[`ASFR_BIT_N] = res[7];
	end
	if (to_flags) begin
		if (arith || logic_op || !keep) begin
			// Flag update wins; computed value is discarded
			nxt_result = result_ff;
		end else begin
			nxt_flags = res & `ASFR_FLAG_MASK;
		end
	end else begin
		nxt_result = res;
	end
end
// ****************************************
// AXI4-Lite write side
// ****************************************
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `ASFR_RESP_OKAY;
		aw_held_ff <= 1'b0;
		w_held_ff <= 1'b0;
		awaddr_ff <= 8'h00;
		wdata_ff <= 32'h0000_0000;
		wstrb_ff <= 4'h0;
		alu_condition_flags_ff <= `ASFR_FLAGS_RST;
		operand_ff <= 8'h00;
		result_ff <= 8'h00;
		opctl_ff <= `ASFR_OPCTL_RST;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			awaddr_ff <= s_axi_awaddr;
			aw_held_ff <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_ff <= s_axi_wdata;
			wstrb_ff <= s_axi_wstrb;
			w_held_ff <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (op_go) begin
			alu_condition_flags_ff <= nxt_flags;
			result_ff <= nxt_result;
		end
		if (do_write) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= `ASFR_RESP_OKAY;
			if (awaddr_ff == `ASFR_FLAGS_OFS) begin
				if (wstrb_ff[0]) begin
					alu_condition_flags_ff <=
						wdata_ff[7:0] & `ASFR_FLAG_MASK;
				end
			end else if (awaddr_ff == `ASFR_OPCTL_OFS) begin
				opctl_ff <= merge(opctl_ff, wdata_ff, wstrb_ff);
			end else if (awaddr_ff == `ASFR_OPERAND_OFS) begin
				if (wstrb_ff[0]) begin
					operand_ff <= wdata_ff[7:0];
				end
			end else if (awaddr_ff != `ASFR_RESULT_OFS) begin
				s_axi_bresp <= `ASFR_RESP_SLVERR;
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end
// ****************************************
// AXI4-Lite read side
// ****************************************
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `ASFR_RESP_OKAY;
	end else begin
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `ASFR_RESP_OKAY;
			if (s_axi_araddr == `ASFR_FLAGS_OFS) begin
				s_axi_rdata <= {24'h000000,
					alu_condition_flags_ff};
			end else if (s_axi_araddr == `ASFR_OPCTL_OFS) begin
				s_axi_rdata <= opctl_ff;
			end else if (s_axi_araddr == `ASFR_OPERAND_OFS) begin
				s_axi_rdata <= {24'h000000, operand_ff};
			end else if (s_axi_araddr == `ASFR_RESULT_OFS) begin
				s_axi_rdata <= {24'h000000, result_ff};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `ASFR_RESP_SLVERR;
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end
endmodule
`default_nettype wire

// [tb/asfr_core_asserts.sv]
// Bus timing and flag register checks bound to the flag register core
`timescale 1ns/1ps
`default_nettype none
module asfr_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] alu_condition_flags_ff
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	property p_upper_zero;
		alu_condition_flags_ff[7:5] == 3'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("top bits set");
	property p_flag_write;
		!$stable(alu_condition_flags_ff) |-> $rose(s_axi_bvalid);
	endproperty
	a_flag_write: assert property (p_flag_write)
		else $error("stray flags");
	// Both held on the take edge, register write and bvalid one edge later
	property p_wr_answer;
		s_wr_taken |=> ##1 s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("no bvalid");
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("no rvalid");
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
	endproperty
	a_b_done: assert property (p_b_done)
		else $error("write not closed");
	property p_r_done;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_r_done: assert property (p_r_done)
		else $error("read not closed");
	property p_wr_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr_busy: assert property (p_wr_busy)
		else $error("ready in response");
endmodule
bind asfr_core asfr_chk chk_i (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.alu_condition_flags_ff(alu_condition_flags_ff)
);
`default_nettype wire

// [tb/asfr_core_tb_top.sv]
// Register level bench for the ALU condition flag register core
`timescale 1ns/1ps
`default_nettype none
module asfr_core_tb_top;
	// ****************************************
	// Bench
	// ****************************************
	logic clk_sys = 1'b0, rst_n = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] alu_condition_flags_ff;
	// Operand, literal, op, result, flags
	logic [39:0] tv [10] = '{40'h7f0100801a, 40'hff01000007,
		40'h1001010f01, 40'h010201ff10, 40'h8001017f09,
		40'h0ff002000d, 40'h0ff003ff19, 40'h5a5a04000d,
		40'h81000b8119, 40'h810005001d};
	int error_cnt = 0, cmp_count = 0;
	always #2 clk_sys = ~clk_sys;
	asfr_core dut (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.alu_condition_flags_ff(alu_condition_flags_ff)
	);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] r = 2'b00);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r = 2'b00);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rresp, r);
		chk(s_axi_rdata, e);
	endtask
	// Second write runs the op; the harmless move stays armed
	task run(input logic [31:0] c);
		wr(8'h04, c);
		wr(8'h04, 32'h0000000a);
	endtask
	task close_out;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		close_out;
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h10, 32'h0, 2'b10);
		wr(8'h10, 32'h1, 2'b10);
		wr(8'h04, 32'h0000000a);
		wr(8'h00, 32'hff);
		rd(8'h00, 32'h1f);
		chk(alu_condition_flags_ff, 8'h1f);
		wr(8'h00, 32'h0a);
		run(32'h15);
		rd(8'h00, 32'h0e);
		// Flag writes use byte lane 0 only
		s_axi_wstrb <= 4'he;
		wr(8'h00, 32'hff);
		s_axi_wstrb <= 4'hf;
		rd(8'h00, 32'h0e);
		wr(8'h00, 32'h15);
		for (int i = 6; i <= 10; i++) begin
			run(32'h003c0200 | i);
			rd(8'h00, 32'h15);
		end
		run(32'h116);
		rd(8'h00, 32'h17);
		wr(8'h00, 32'h0);
		run(32'h00800010);
		rd(8'h00, 32'h10);
		rd(8'h0c, 32'h0);
		for (int i = 0; i < 10; i++) begin
			wr(8'h08, {24'h0, tv[i][39:32]});
			run({8'h0, tv[i][31:24], 8'h0, tv[i][23:16]});
			rd(8'h0c, {24'h0, tv[i][15:8]});
			rd(8'h00, {24'h0, tv[i][7:0]});
		end
		wr(8'h0c, 32'h55);
		rd(8'h0c, 32'h0);
		close_out;
	end
endmodule
`default_nettype wire
